// file: core/dc_sync_local_cycle.v
/*
 Local process-data cycle synchroniser with an AXI4-Lite register slave.
 Assumes sync pulses and frame_done are one-cycle pulses synchronous to
 core_clk, and that the master runs one read and one write at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dc_sync_consts.vh"

module dc_sync_local_cycle #(
    parameter ADDR_W = 12,
    parameter [31:0] MIN_CYCLE_NS = 32'd100000,
    parameter [31:0] CALC_COPY_NS = 32'd10000,
    parameter [31:0] DELAY_NS = 32'd1000
) (
    input wire core_clk,
    input wire srst,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire primary_sync_pulse,
    input wire secondary_sync_pulse,
    input wire frame_done,
    input wire toggle_fail,
    output reg cycle_start,
    output reg cycle_busy,
    output reg outputs_valid,
    output reg input_latch,
    output reg irq
);

    // ==========================================================
    // helpers

    // counters stick at full scale rather than wrap to a small value
    function [15:0] sat_inc;
        input [15:0] v;
        begin
            sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
        end
    endfunction

    // byte-lane merge of a write into a stored word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i])
                    merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // ==========================================================
    // state

    reg [31:0] period_q;
    reg [15:0] out_type_q;
    reg [15:0] in_type_q;
    reg [31:0] out_shift_q;
    reg [31:0] in_shift_q;
    reg [15:0] get_cycle_q;
    reg [15:0] too_small_q;
    reg [15:0] missed_q;
    reg [15:0] toggle_q;
    reg sync_err_q;
    reg [31:0] elapsed_q;
    reg seen_pulse_q;
    reg out_pend_q;
    reg in_pend_q;
    reg [`IRQ_W-1:0] irq_stat_q;
    reg [`IRQ_W-1:0] irq_en_q;
    reg aw_full_q;
    reg w_full_q;
    reg [ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    wire [11:0] waddr = awaddr_q[11:0];
    wire [11:0] raddr = s_axi_araddr[11:0];
    wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;

    // ==========================================================
    // derived fields

    // shift setting shown to the master follows the live configuration
    reg [1:0] shift_mode;
    always @* begin
        if (out_type_q == `TYPE_SECONDARY || in_type_q == `TYPE_SECONDARY)
            shift_mode = `SHIFT_SECONDARY;
        else if (out_shift_q != 32'h0 || in_shift_q != 32'h0)
            shift_mode = `SHIFT_TIMER;
        else
            shift_mode = `SHIFT_NONE;
    end

    wire [15:0] types_word = `TYPES_DC | {10'h000, shift_mode, 4'h0};

    // elapsed time of the cycle that a pulse now closes
    wire [31:0] cycle_ns = elapsed_q + `CLK_PERIOD_NS;

    // ==========================================================
    // register decode

    function map_hit;
        input [11:0] a;
        input is_wr;
        reg [11:0] s;
        begin
            s = a & `SUB_MASK;
            map_hit = 1'b0;
            if ((a & `SET_MASK) == `OUT_BASE || (a & `SET_MASK) == `IN_BASE) begin
                case (s)
                    `SUB_SYNC_TYPE, `SUB_SHIFT, `SUB_GET_CYCLE: map_hit = 1'b1;
                    `SUB_CYCLE, `SUB_TYPES, `SUB_MIN_CYCLE, `SUB_CALC_COPY,
                    `SUB_DELAY, `SUB_TOO_SMALL, `SUB_MISSED, `SUB_TOGGLE,
                    `SUB_SYNC_ERR: map_hit = !is_wr;
                    default: map_hit = 1'b0;
                endcase
            end else begin
                case (a)
                    `PERIOD_ADDR, `IRQ_ENABLE: map_hit = 1'b1;
                    `IRQ_STATUS: map_hit = !is_wr;
                    `IRQ_CLEAR: map_hit = 1'b1;
                    default: map_hit = 1'b0;
                endcase
            end
        end
    endfunction

    // read mux; the input set mirrors the shared entries of the output set
    reg [31:0] rd_word;
    reg rd_in;
    always @* begin
        rd_in = ((raddr & `SET_MASK) == `IN_BASE);
        rd_word = 32'h0;
        if (rd_in || (raddr & `SET_MASK) == `OUT_BASE) begin
            case (raddr & `SUB_MASK)
                `SUB_SYNC_TYPE: rd_word = {16'h0, rd_in ? in_type_q : out_type_q};
                `SUB_CYCLE: rd_word = period_q;
                `SUB_SHIFT: rd_word = rd_in ? in_shift_q : out_shift_q;
                `SUB_TYPES: rd_word = {16'h0, types_word};
                `SUB_MIN_CYCLE: rd_word = MIN_CYCLE_NS;
                `SUB_CALC_COPY: rd_word = CALC_COPY_NS;
                `SUB_GET_CYCLE: rd_word = {16'h0, get_cycle_q};
                `SUB_DELAY: rd_word = DELAY_NS;
                `SUB_TOO_SMALL: rd_word = {16'h0, too_small_q};
                `SUB_MISSED: rd_word = {16'h0, missed_q};
                `SUB_TOGGLE: rd_word = {16'h0, toggle_q};
                `SUB_SYNC_ERR: rd_word = {31'h0, sync_err_q};
                default: rd_word = 32'h0;
            endcase
        end else begin
            case (raddr)
                `PERIOD_ADDR: rd_word = period_q;
                `IRQ_STATUS: rd_word = {29'h0, irq_stat_q};
                `IRQ_ENABLE: rd_word = {29'h0, irq_en_q};
                default: rd_word = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // axi write channel

    // address and data are caught in either order; answer follows both
    always @(posedge core_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= map_hit(waddr, 1'b1) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // axi read channel

    always @(posedge core_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (do_read) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= map_hit(raddr, 1'b0) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // configuration registers

    // only the two documented sync type codes are accepted
    wire [31:0] type_wr = merge(32'h0, wdata_q, wstrb_q);
    wire type_ok = (type_wr[15:0] == `TYPE_PRIMARY) || (type_wr[15:0] == `TYPE_SECONDARY);
    // get-cycle entry keeps only the low half of the merged word
    wire [31:0] gc_wr = merge({16'h0, get_cycle_q}, wdata_q, wstrb_q);
    always @(posedge core_clk) begin
        if (srst) begin
            period_q <= 32'h0;
            out_type_q <= `TYPE_PRIMARY;
            in_type_q <= `TYPE_PRIMARY;
            out_shift_q <= 32'h0;
            in_shift_q <= 32'h0;
            get_cycle_q <= 16'h0;
            irq_en_q <= {`IRQ_W{1'b0}};
        end else if (do_write) begin
            case (waddr)
                `PERIOD_ADDR: period_q <= merge(period_q, wdata_q, wstrb_q);
                `OUT_BASE | `SUB_SYNC_TYPE: if (type_ok) out_type_q <= type_wr[15:0];
                `IN_BASE | `SUB_SYNC_TYPE: if (type_ok) in_type_q <= type_wr[15:0];
                `OUT_BASE | `SUB_SHIFT: out_shift_q <= merge(out_shift_q, wdata_q, wstrb_q);
                `IN_BASE | `SUB_SHIFT: in_shift_q <= merge(in_shift_q, wdata_q, wstrb_q);
                `OUT_BASE | `SUB_GET_CYCLE,
                `IN_BASE | `SUB_GET_CYCLE:
                    get_cycle_q <= gc_wr[15:0];
                `IRQ_ENABLE: irq_en_q <= wdata_q[`IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // local cycle timing

    // elapsed time since the last primary pulse, in ns
    always @(posedge core_clk) begin
        if (srst) begin
            elapsed_q <= 32'h0;
            seen_pulse_q <= 1'b0;
            cycle_start <= 1'b0;
            cycle_busy <= 1'b0;
        end else begin
            cycle_start <= primary_sync_pulse;
            if (primary_sync_pulse) begin
                elapsed_q <= 32'h0;
                seen_pulse_q <= 1'b1;
                cycle_busy <= 1'b1;
            end else begin
                if (elapsed_q <= 32'hffffffff - `CLK_PERIOD_NS)
                    elapsed_q <= cycle_ns;
                if (frame_done)
                    cycle_busy <= 1'b0;
            end
        end
    end

    // shifted output-valid and input-latch points
    always @(posedge core_clk) begin
        if (srst) begin
            out_pend_q <= 1'b0;
            in_pend_q <= 1'b0;
            outputs_valid <= 1'b0;
            input_latch <= 1'b0;
        end else begin
            outputs_valid <= 1'b0;
            input_latch <= 1'b0;
            if (primary_sync_pulse) begin
                out_pend_q <= 1'b1;
                in_pend_q <= 1'b1;
            end else begin
                // secondary mode waits for the secondary pulse, else the timer
                if (out_pend_q && (out_type_q == `TYPE_SECONDARY ? secondary_sync_pulse
                        : elapsed_q >= out_shift_q)) begin
                    out_pend_q <= 1'b0;
                    outputs_valid <= 1'b1;
                end
                if (in_pend_q && (in_type_q == `TYPE_SECONDARY ? secondary_sync_pulse
                        : elapsed_q >= in_shift_q)) begin
                    in_pend_q <= 1'b0;
                    input_latch <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // error counters

    // a pulse that finds the last frame unfinished is a missed event
    wire missed_ev = primary_sync_pulse && cycle_busy && !frame_done;
    wire small_ev = primary_sync_pulse && seen_pulse_q && cycle_ns < MIN_CYCLE_NS;
    always @(posedge core_clk) begin
        if (srst) begin
            too_small_q <= 16'h0;
            missed_q <= 16'h0;
            toggle_q <= 16'h0;
            sync_err_q <= 1'b0;
        end else begin
            if (small_ev)
                too_small_q <= sat_inc(too_small_q);
            if (missed_ev)
                missed_q <= sat_inc(missed_q);
            if (toggle_fail)
                toggle_q <= sat_inc(toggle_q);
            // flag follows the most recent cycle boundary
            if (primary_sync_pulse)
                sync_err_q <= missed_ev;
        end
    end

    // ==========================================================
    // interrupts

    // set wins over a clear written in the same cycle
    wire [`IRQ_W-1:0] irq_set = {small_ev, missed_ev, primary_sync_pulse};
    wire irq_clr_wr = do_write && waddr == `IRQ_CLEAR;
    wire [`IRQ_W-1:0] irq_clr = irq_clr_wr ? wdata_q[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
    wire [`IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
    always @(posedge core_clk) begin
        if (srst) begin
            irq_stat_q <= {`IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq <= |(irq_stat_d & irq_en_q);
        end
    end

endmodule // dc_sync_local_cycle
`default_nettype wire

// file: core/dc_sync_consts.vh
/*
 Constants for the local-cycle synchroniser: register offsets, field
 layouts, codes and the clock rate.
 Assumes it is included by bare name from the design file.
*/
// What this block does
// - Every primary sync pulse starts a new local processing cycle.
// - Frame handling must finish before the next primary sync pulse arrives.
// - Without shifting both sync type entries report 0x02, locked to the primary pulse.
// - Output cycle time reads the 32-bit primary pulse period register at 0x9a0.
// - Supported types bits 3:2 read 01, plain distributed-clock operation.
// - The input set returns the output set's cycle, types, minimum, get-cycle and counters.
// - The sync error flag exists because the missed-event counter is built.
// - Output-valid is delayed by the local shift time, or by the secondary pulse for type 0x03.
// - Output shift counts from the primary pulse; secondary mode waits for its pulse.
// - Input latch is delayed by its shift time, or by the secondary pulse for type 0x03.
// - A cycle-too-small counter is kept; missed-event and toggle-failed counters too.
// - The get-cycle-time entry is writable and read back.
// - Supported types bits 5:4 show 00 no shift, 01 local timer, 10 secondary pulse.
`ifndef DC_SYNC_CONSTS_VH
`define DC_SYNC_CONSTS_VH

// ==========================================================
// clock
`define CLK_PERIOD_NS 32'd4

// ==========================================================
// register map
`define SET_MASK 12'hf00
`define OUT_BASE 12'h000
`define IN_BASE 12'h100
`define SUB_MASK 12'h0ff
`define SUB_SYNC_TYPE 12'h004
`define SUB_CYCLE 12'h008
`define SUB_SHIFT 12'h00c
`define SUB_TYPES 12'h010
`define SUB_MIN_CYCLE 12'h014
`define SUB_CALC_COPY 12'h018
`define SUB_GET_CYCLE 12'h020
`define SUB_DELAY 12'h024
`define SUB_TOO_SMALL 12'h02c
`define SUB_MISSED 12'h030
`define SUB_TOGGLE 12'h038
`define SUB_SYNC_ERR 12'h080
`define IRQ_STATUS 12'h200
`define IRQ_ENABLE 12'h204
`define IRQ_CLEAR 12'h208
`define PERIOD_ADDR 12'h9a0

// ==========================================================
// codes and fields
`define TYPE_PRIMARY 16'h0002
`define TYPE_SECONDARY 16'h0003
`define TYPES_DC 16'h0004
`define SHIFT_NONE 2'b00
`define SHIFT_TIMER 2'b01
`define SHIFT_SECONDARY 2'b10
`define IRQ_W 3
`define IRQ_CYCLE 0
`define IRQ_MISSED 1
`define IRQ_TOO_SMALL 2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: verif/dc_sync_monitor.sv
/*
 Port checker for the local-cycle synchroniser.
 Assumes one clock, core_clk, and srst high for reset.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// checker
module dc_sync_monitor (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic primary_sync_pulse,
    input wire logic frame_done,
    input wire logic cycle_start,
    input wire logic cycle_busy,
    input wire logic outputs_valid,
    input wire logic input_latch,
    input wire logic irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // cycle start follows each primary pulse, and nothing else
    chk_start_follows: assert property (primary_sync_pulse |=> cycle_start)
        else $error("cycle start missing after primary pulse");
    chk_start_cause: assert property (cycle_start |-> $past(primary_sync_pulse))
        else $error("cycle start without primary pulse");
    chk_start_single: assert property (cycle_start |=> !cycle_start)
        else $error("cycle start longer than one cycle");
    // busy spans pulse to frame done
    chk_busy_set: assert property (primary_sync_pulse |=> cycle_busy)
        else $error("busy not set by primary pulse");
    chk_busy_clear: assert property (frame_done && !primary_sync_pulse |=> !cycle_busy)
        else $error("busy not cleared by frame done");
    chk_busy_hold: assert property (cycle_busy && !frame_done |=> cycle_busy)
        else $error("busy dropped without frame done");
    // shifted points are single pulses
    chk_valid_once: assert property (outputs_valid |=> !outputs_valid)
        else $error("outputs valid longer than one cycle");
    chk_latch_once: assert property (input_latch |=> !input_latch)
        else $error("input latch longer than one cycle");
    // register answers come at the stated latency
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    cov_start: cover property (cycle_start);
    cov_valid: cover property (outputs_valid);
    cov_irq: cover property (irq);
endmodule // dc_sync_monitor
bind dc_sync_local_cycle dc_sync_monitor u_mon (.core_clk, .srst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .primary_sync_pulse, .frame_done, .cycle_start,
    .cycle_busy, .outputs_valid, .input_latch, .irq);
`default_nettype wire

// file: verif/sync_master_model.sv
/*
 Far-side model: source of sync pulses and frame events.
 Assumes its task is called from the bench's clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// pulse source
module sync_master_model (
    input wire logic core_clk,
    output wire logic primary_sync_pulse,
    output wire logic secondary_sync_pulse,
    output wire logic frame_done,
    output wire logic toggle_fail
);
    logic [3:0] ev_q = 4'h0;
    // one-cycle pulses, each launched just after an edge
    assign primary_sync_pulse = ev_q[0];
    assign secondary_sync_pulse = ev_q[1];
    assign frame_done = ev_q[2];
    assign toggle_fail = ev_q[3];
    // k picks the event, d edges of delay come first
    task automatic pulse(input int k, input int d);
        begin
            repeat (d) @(posedge core_clk);
            ev_q[k] <= 1'h1;
            @(posedge core_clk);
            ev_q[k] <= 1'h0;
        end
    endtask
endmodule // sync_master_model
`default_nettype wire

// file: verif/testbench.sv
/*
 Self-checking bench for the local-cycle synchroniser.
 Assumes the pulse model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
// ============================================================
// bench
module testbench;
    logic core_clk = 1'h0;
    logic srst = 1'h1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire prim, sec, fdone, tfail, cstart, busy, ov, il, irq;
    int err_total = 0, checked = 0;
    logic [11:0] ra [11] = '{12'h004, 12'h104, 12'h010, 12'h110, 12'h00c, 12'h02c,
        12'h030, 12'h080, 12'h200, 12'h014, 12'h114};
    logic [31:0] re [11] = '{32'h2, 32'h2, 32'h4, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h28, 32'h28};
    // short minimum cycle so the too-small case fits the run
    dc_sync_local_cycle #(.MIN_CYCLE_NS(32'h28)) dut (.core_clk(core_clk), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .primary_sync_pulse(prim),
        .secondary_sync_pulse(sec), .frame_done(fdone), .toggle_fail(tfail),
        .cycle_start(cstart), .cycle_busy(busy), .outputs_valid(ov),
        .input_latch(il), .irq(irq));
    sync_master_model m (.core_clk(core_clk), .primary_sync_pulse(prim),
        .secondary_sync_pulse(sec), .frame_done(fdone), .toggle_fail(tfail));
    // 250 MHz clock
    initial forever #2 core_clk = ~core_clk;
    task automatic conclude;
        begin
            $display("checked %0d err_total %0d", checked, err_total);
            if (err_total == 0 && checked > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // bounded waits: a hang ends the run as a mismatch
    task automatic tick(inout int n);
        begin
            n++;
            if (n > 100) begin
                err_total++;
                conclude();
            end
        end
    endtask
    // ready is sampled at the negedge, which equals its value at the next edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, bv, pa, pw;
        logic [1:0] r;
        begin
            n = 0;
            bv = 1'h0;
            pa = 1'h1;
            pw = 1'h1;
            @(posedge core_clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            while (pa || pw) begin
                @(negedge core_clk);
                ta = awready;
                tw = wready;
                @(posedge core_clk);
                if (ta) begin
                    awvalid <= 1'h0;
                    pa = 1'h0;
                end
                if (tw) begin
                    wvalid <= 1'h0;
                    pw = 1'h0;
                end
                tick(n);
            end
            while (!bv) begin
                @(negedge core_clk);
                bv = bvalid;
                r = bresp;
                @(posedge core_clk);
                tick(n);
            end
            bready <= 1'h0;
            `CHK("bresp", er, r)
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        logic ta, rv;
        logic [1:0] r;
        logic [31:0] d;
        begin
            n = 0;
            rv = 1'h0;
            @(posedge core_clk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            while (!rv) begin
                @(negedge core_clk);
                ta = arready;
                rv = rvalid;
                d = rdata;
                r = rresp;
                @(posedge core_clk);
                if (ta) arvalid <= 1'h0;
                tick(n);
            end
            rready <= 1'h0;
            `CHK("rdata", e, d)
            `CHK("rresp", er, r)
        end
    endtask
    // cycles from the pulse edge to each shifted point
    task automatic meas(input int eo, input int ei);
        int c, o, i;
        begin
            o = -1;
            i = -1;
            for (c = 0; c < 12; c++) begin
                @(negedge core_clk);
                if (c == 0) `CHK("cycle_start", 1'h1, cstart)
                if (c == 0) `CHK("cycle_busy", 1'h1, busy)
                if (ov === 1'h1) o = c;
                if (il === 1'h1) i = c;
            end
            `CHK("outputs_valid", eo, o)
            `CHK("input_latch", ei, i)
            // hand back on a rising edge so the next stimulus starts there
            @(posedge core_clk);
        end
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'h0;
        for (int k = 0; k < 11; k++) rd(ra[k], re[k], 2'h0);
        wr(12'h9a0, 32'h1234, 2'h0);
        rd(12'h008, 32'h1234, 2'h0);
        rd(12'h108, 32'h1234, 2'h0);
        wr(12'h020, 32'h55, 2'h0);
        rd(12'h120, 32'h55, 2'h0);
        wr(12'h008, 32'h1, 2'h2);
        rd(12'h008, 32'h1234, 2'h0);
        rd(12'h300, 32'h0, 2'h2);
        wr(12'h004, 32'h7, 2'h0);
        rd(12'h004, 32'h2, 2'h0);
        // interrupt on cycle start, then cleared
        wr(12'h204, 32'h1, 2'h0);
        m.pulse(0, 0);
        meas(1, 1);
        @(negedge core_clk);
        `CHK("irq", 1'h1, irq)
        rd(12'h200, 32'h1, 2'h0);
        m.pulse(2, 0);
        wr(12'h208, 32'h1, 2'h0);
        @(negedge core_clk);
        `CHK("irq", 1'h0, irq)
        wr(12'h204, 32'h0, 2'h0);
        // local shift timers
        wr(12'h00c, 32'h8, 2'h0);
        wr(12'h10c, 32'hc, 2'h0);
        rd(12'h010, 32'h14, 2'h0);
        m.pulse(0, 0);
        meas(3, 4);
        m.pulse(2, 0);
        // secondary pulse, one set at a time
        wr(12'h004, 32'h3, 2'h0);
        rd(12'h010, 32'h24, 2'h0);
        rd(12'h104, 32'h2, 2'h0);
        m.pulse(0, 0);
        fork
            m.pulse(1, 4);
            meas(5, 4);
        join
        m.pulse(2, 0);
        wr(12'h004, 32'h2, 2'h0);
        wr(12'h104, 32'h3, 2'h0);
        m.pulse(0, 0);
        fork
            m.pulse(1, 6);
            meas(3, 7);
        join
        m.pulse(2, 0);
        wr(12'h104, 32'h2, 2'h0);
        // pulse while busy counts a missed event
        m.pulse(0, 0);
        meas(3, 4);
        m.pulse(0, 0);
        meas(3, 4);
        rd(12'h030, 32'h1, 2'h0);
        rd(12'h130, 32'h1, 2'h0);
        rd(12'h080, 32'h1, 2'h0);
        m.pulse(2, 0);
        // a short cycle counts as too small and reloads the error flag
        m.pulse(0, 0);
        m.pulse(2, 0);
        m.pulse(0, 0);
        m.pulse(2, 0);
        rd(12'h02c, 32'h1, 2'h0);
        rd(12'h12c, 32'h1, 2'h0);
        rd(12'h080, 32'h0, 2'h0);
        m.pulse(3, 0);
        rd(12'h038, 32'h1, 2'h0);
        rd(12'h138, 32'h1, 2'h0);
        // masked status, then enabled, then cleared
        rd(12'h200, 32'h7, 2'h0);
        @(negedge core_clk);
        `CHK("irq", 1'h0, irq)
        wr(12'h204, 32'h4, 2'h0);
        @(negedge core_clk);
        `CHK("irq", 1'h1, irq)
        wr(12'h208, 32'h7, 2'h0);
        @(negedge core_clk);
        `CHK("irq", 1'h0, irq)
        rd(12'h200, 32'h0, 2'h0);
        rd(12'h208, 32'h0, 2'h0);
        conclude();
    end
endmodule // testbench
`default_nettype wire
